//--- logic/xcvr_debug_cfg.svh
// Constants for the transceiver debug and reconfiguration port
`ifndef XCVR_DEBUG_CFG_SVH
`define XCVR_DEBUG_CFG_SVH
`define RECONFIG_ADDR_W 9
`define RECONFIG_DATA_W 16
`define RECONFIG_DEPTH 512
`define LOOPBACK_W 3
`define MONITOR_W 17
`define LOOPBACK_DEFAULT 3'h0
`define MONITOR_LOWEND_W 15
`define RDATA_RESET 16'h0000
`endif

//--- logic/xcvr_debug_pkg.sv
// Types for the transceiver debug and reconfiguration port
`include "xcvr_debug_cfg.svh"
package xcvr_debug_pkg;
    typedef logic [`RECONFIG_ADDR_W-1:0] addr_type;
    typedef logic [`RECONFIG_DATA_W-1:0] data_type;
    typedef logic [`LOOPBACK_W-1:0] loop_type;
    typedef logic [`MONITOR_W-1:0] monitor_type;
    typedef enum logic {VARIANT_LOWEND, VARIANT_HIGHEND} variant_type;
endpackage

//--- logic/reconfig_mem.sv
// Reconfiguration register memory with registered read data
`timescale 1ns/10ps
`include "xcvr_debug_cfg.svh"
module reconfig_mem (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [`RECONFIG_ADDR_W-1:0] addr,
    input wire logic [`RECONFIG_DATA_W-1:0] wdata,
    output logic [`RECONFIG_DATA_W-1:0] rdata
);
    logic [`RECONFIG_DATA_W-1:0] mem_reg [0:`RECONFIG_DEPTH-1];

    // Read-first: read data shows the old word on a write
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[addr] <= wdata;
        end
        rdata <= mem_reg[addr];
    end
endmodule

//--- logic/xcvr_debug_port.sv
// Transceiver debug control and status port with reconfiguration access
`timescale 1ns/10ps
`include "xcvr_debug_cfg.svh"
// Notes on behaviour
// - With the debug option off, every control towards the transceiver takes its default value.
// - With the reconfiguration option off, no access is taken and ready never rises.
// - Address is 9 bits, write and read data 16 bits, all on the reconfiguration clock.
// - Ready pulses once to end a write and to mark valid read data.
// - Loopback select is forced to default when the receive clock is the recovered clock.
// - Transmit inhibit holds the transmit output steady while it is high.
// - The 17-bit monitor shows status, only low bits valid on a narrower variant.
// - Low-power equaliser reset and high-frequency override act on the low-end variant only.
module xcvr_debug_port
    import xcvr_debug_pkg::*;
#(
    parameter bit DEBUG_ENABLE = 1'b1,
    parameter bit RECONFIG_ENABLE = 1'b1,
    parameter xcvr_debug_pkg::variant_type VARIANT = xcvr_debug_pkg::VARIANT_LOWEND
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reconfig_en,
    input wire logic reconfig_write_en,
    input wire xcvr_debug_pkg::addr_type reconfig_addr,
    input wire xcvr_debug_pkg::data_type reconfig_wdata,
    output xcvr_debug_pkg::data_type reconfig_rdata,
    output logic reconfig_ready,
    input wire logic rx_reset_complete_in,
    output logic rx_reset_complete,
    input wire xcvr_debug_pkg::loop_type loopback_select,
    input wire logic rx_gmii_clock_source,
    input wire logic tx_output_inhibit,
    input wire logic [7:0] tx_data_in,
    output logic [7:0] tx_data_out,
    output xcvr_debug_pkg::loop_type loopback_to_xcvr,
    input wire xcvr_debug_pkg::monitor_type monitor_from_xcvr,
    output xcvr_debug_pkg::monitor_type digital_monitor_out,
    input wire logic rx_lowpower_eq_reset,
    input wire logic rx_lowpower_hf_override_en,
    output logic lowpower_eq_reset_to_xcvr,
    output logic hf_override_to_xcvr
);
    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] done_sync_reg;
    loop_type loop_s1_reg;
    loop_type loop_s2_reg;
    logic [1:0] src_sync_reg;
    logic [1:0] lpm_sync_reg;
    logic [1:0] hf_sync_reg;
    monitor_type mon_s1_reg;
    monitor_type mon_s2_reg;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_sync_reg <= 2'h0;
            src_sync_reg <= 2'h0;
            lpm_sync_reg <= 2'h0;
            hf_sync_reg <= 2'h0;
            loop_s1_reg <= `LOOPBACK_DEFAULT;
            loop_s2_reg <= `LOOPBACK_DEFAULT;
            mon_s1_reg <= '0;
            mon_s2_reg <= '0;
        end else begin
            done_sync_reg <= {done_sync_reg[0], rx_reset_complete_in};
            src_sync_reg <= {src_sync_reg[0], rx_gmii_clock_source};
            lpm_sync_reg <= {lpm_sync_reg[0], rx_lowpower_eq_reset};
            hf_sync_reg <= {hf_sync_reg[0], rx_lowpower_hf_override_en};
            loop_s1_reg <= loopback_select;
            loop_s2_reg <= loop_s1_reg;
            mon_s1_reg <= monitor_from_xcvr;
            mon_s2_reg <= mon_s1_reg;
        end
    end

    // ==========================================================
    // Control selection
    // ==========================================================
    wire lowend = (VARIANT == VARIANT_LOWEND);
    // Recovered clock as receive source breaks loopback timing, so force default
    wire loop_blocked = src_sync_reg[1];
    wire loop_type loopback_next = (DEBUG_ENABLE && !loop_blocked) ? loop_s2_reg
                                   : `LOOPBACK_DEFAULT;
    wire lpm_next = DEBUG_ENABLE && lowend && lpm_sync_reg[1];
    wire hf_next = DEBUG_ENABLE && lowend && hf_sync_reg[1];
    // Inhibit is same-clock logic, so no synchroniser; zeros are the steady level
    wire inhibit_on = DEBUG_ENABLE && tx_output_inhibit;
    wire [7:0] tx_next = inhibit_on ? 8'h00 : tx_data_in;
    wire monitor_type monitor_next = DEBUG_ENABLE ? mon_s2_reg : '0;

    // Registered outputs towards transceiver and user
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loopback_to_xcvr <= `LOOPBACK_DEFAULT;
            lowpower_eq_reset_to_xcvr <= 1'b0;
            hf_override_to_xcvr <= 1'b0;
            tx_data_out <= 8'h00;
            digital_monitor_out <= '0;
            rx_reset_complete <= 1'b0;
        end else begin
            loopback_to_xcvr <= loopback_next;
            lowpower_eq_reset_to_xcvr <= lpm_next;
            hf_override_to_xcvr <= hf_next;
            tx_data_out <= tx_next;
            digital_monitor_out <= monitor_next;
            rx_reset_complete <= done_sync_reg[1];
        end
    end

    // ==========================================================
    // Reconfiguration access
    // ==========================================================
    logic busy_reg;
    logic write_reg;
    data_type mem_rdata;
    // Access taken only when the option exists, nothing is outstanding
    wire take = RECONFIG_ENABLE && reconfig_en && !busy_reg;
    wire mem_wr = take && reconfig_write_en;

    reconfig_mem mem_inst (
        .clk(clk),
        .wr_en(mem_wr),
        .addr(reconfig_addr),
        .wdata(reconfig_wdata),
        .rdata(mem_rdata)
    );

    // Ready follows two edges after the request; read data lands with it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            write_reg <= 1'b0;
            reconfig_ready <= 1'b0;
            reconfig_rdata <= `RDATA_RESET;
        end else begin
            busy_reg <= take;
            write_reg <= mem_wr;
            reconfig_ready <= busy_reg;
            if (busy_reg && !write_reg) begin
                reconfig_rdata <= mem_rdata;
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_take;
        take;
    endsequence
    sequence s_ready_after;
        ##2 reconfig_ready;
    endsequence
    property p_ready_timing;
        @(posedge clk) disable iff (rst) s_take |-> s_ready_after;
    endproperty
    a_ready_timing: assert property (p_ready_timing) else $error("ready late");
    property p_ready_cause;
        @(posedge clk) disable iff (rst) reconfig_ready |-> $past(take, 2);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
    property p_ready_pulse;
        @(posedge clk) disable iff (rst) reconfig_ready |=> !reconfig_ready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready not pulse");
    property p_no_reconfig;
        @(posedge clk) disable iff (rst) !RECONFIG_ENABLE |-> !reconfig_ready && !busy_reg;
    endproperty
    a_no_reconfig: assert property (p_no_reconfig) else $error("access while off");
    property p_loop_block;
        @(posedge clk) disable iff (rst)
            loop_blocked |=> loopback_to_xcvr == `LOOPBACK_DEFAULT;
    endproperty
    a_loop_block: assert property (p_loop_block) else $error("loopback leaked");
    property p_inhibit;
        @(posedge clk) disable iff (rst) inhibit_on |=> tx_data_out == 8'h00;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("tx not steady");
    property p_lowend;
        @(posedge clk) disable iff (rst)
            !lowend |-> !lowpower_eq_reset_to_xcvr && !hf_override_to_xcvr;
    endproperty
    a_lowend: assert property (p_lowend) else $error("lpm on high end");
    property p_defaults;
        @(posedge clk) disable iff (rst)
            !DEBUG_ENABLE |-> loopback_to_xcvr == `LOOPBACK_DEFAULT && !hf_override_to_xcvr;
    endproperty
    a_defaults: assert property (p_defaults) else $error("default missing");
    property p_monitor;
        @(posedge clk) disable iff (rst)
            DEBUG_ENABLE |-> ##3 digital_monitor_out == $past(monitor_from_xcvr, 3);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor wrong");
    // Read data moves only when a read completes, so a write never disturbs it
    property p_rdata_hold;
        @(posedge clk) disable iff (rst)
            !(busy_reg && !write_reg) |=> $stable(reconfig_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    // Without inhibit the transmit byte passes after one register
    property p_tx_pass;
        @(posedge clk) disable iff (rst) !inhibit_on |=> tx_data_out == $past(tx_data_in);
    endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("tx byte lost");
    // Low-end part forwards both equaliser controls through the synchroniser
    property p_lowend_pass;
        @(posedge clk) disable iff (rst)
            DEBUG_ENABLE && lowend |-> ##3
                lowpower_eq_reset_to_xcvr == $past(rx_lowpower_eq_reset, 3)
                && hf_override_to_xcvr == $past(rx_lowpower_hf_override_en, 3);
    endproperty
    a_lowend_pass: assert property (p_lowend_pass) else $error("lpm not passed");
    // A write ends with ready and leaves the read data as it was
    sequence s_write_take;
        take && reconfig_write_en;
    endsequence
    property p_write_done;
        @(posedge clk) disable iff (rst)
            s_write_take |-> s_ready_after ##0 $stable(reconfig_rdata);
    endproperty
    a_write_done: assert property (p_write_done) else $error("write not done");
endmodule

//--- bench/xcvr_far_model.sv
// Behavioural transceiver side: receive reset completion and status word
`timescale 1ns/10ps
module xcvr_far_model (
    input wire logic clk,
    input wire logic rst,
    output logic rx_reset_complete_in,
    output logic [16:0] monitor_from_xcvr
);
    logic [3:0] wait_reg;
    // Reset done rises late, status steps every cycle so stale values show
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
            rx_reset_complete_in <= 1'b0;
            monitor_from_xcvr <= 17'h00000;
        end else begin
            wait_reg <= wait_reg + {3'h0, ~&wait_reg};
            rx_reset_complete_in <= &wait_reg;
            monitor_from_xcvr <= monitor_from_xcvr + 17'h0A5A5;
        end
    end
endmodule

//--- bench/xcvr_debug_reconfig_port_test.sv
// Self-checking bench for the transceiver debug and reconfiguration port
`timescale 1ns/10ps
module xcvr_debug_reconfig_port_test;
    import xcvr_debug_pkg::*;
    logic clk, rst, en, we, src, inh, eqr, hfo, rdy, rdy_off, rrc_in, rrc;
    logic eq_x, hf_x, eq_off, hf_off, eq_hi, hf_hi, chk_on;
    addr_type addr;
    addr_type wa [0:7];
    data_type wdata, rdata;
    data_type mem [0:511];
    loop_type loop, loop_x, loop_off;
    monitor_type mon, mon_out;
    logic [7:0] txd, txq, tx_off;
    logic [32:0] hist [0:3];
    int err_count, checks_done, seed, cycles, i;
    // Full-featured low-end device, one with both options off, one high-end
    xcvr_debug_port u_dut (.clk(clk), .rst(rst), .reconfig_en(en), .reconfig_write_en(we),
        .reconfig_addr(addr), .reconfig_wdata(wdata), .reconfig_rdata(rdata),
        .reconfig_ready(rdy), .rx_reset_complete_in(rrc_in), .rx_reset_complete(rrc),
        .loopback_select(loop), .rx_gmii_clock_source(src), .tx_output_inhibit(inh),
        .tx_data_in(txd), .tx_data_out(txq), .loopback_to_xcvr(loop_x),
        .monitor_from_xcvr(mon), .digital_monitor_out(mon_out), .rx_lowpower_eq_reset(eqr),
        .rx_lowpower_hf_override_en(hfo), .lowpower_eq_reset_to_xcvr(eq_x),
        .hf_override_to_xcvr(hf_x));
    xcvr_debug_port #(.DEBUG_ENABLE(1'b0), .RECONFIG_ENABLE(1'b0), .VARIANT(VARIANT_HIGHEND))
    u_dut_off (.clk(clk), .rst(rst), .reconfig_en(en), .reconfig_write_en(we),
        .reconfig_addr(addr), .reconfig_wdata(wdata), .reconfig_rdata(),
        .reconfig_ready(rdy_off), .rx_reset_complete_in(rrc_in), .rx_reset_complete(),
        .loopback_select(loop), .rx_gmii_clock_source(src), .tx_output_inhibit(inh),
        .tx_data_in(txd), .tx_data_out(tx_off), .loopback_to_xcvr(loop_off),
        .monitor_from_xcvr(mon), .digital_monitor_out(), .rx_lowpower_eq_reset(eqr),
        .rx_lowpower_hf_override_en(hfo), .lowpower_eq_reset_to_xcvr(eq_off),
        .hf_override_to_xcvr(hf_off));
    xcvr_debug_port #(.VARIANT(VARIANT_HIGHEND)) u_dut_high (.clk(clk), .rst(rst),
        .reconfig_en(en), .reconfig_write_en(we), .reconfig_addr(addr), .reconfig_wdata(wdata),
        .reconfig_rdata(), .reconfig_ready(), .rx_reset_complete_in(rrc_in),
        .rx_reset_complete(), .loopback_select(loop), .rx_gmii_clock_source(src),
        .tx_output_inhibit(inh), .tx_data_in(txd), .tx_data_out(), .loopback_to_xcvr(),
        .monitor_from_xcvr(mon), .digital_monitor_out(), .rx_lowpower_eq_reset(eqr),
        .rx_lowpower_hf_override_en(hfo), .lowpower_eq_reset_to_xcvr(eq_hi),
        .hf_override_to_xcvr(hf_hi));
    xcvr_far_model u_far (.clk(clk), .rst(rst), .rx_reset_complete_in(rrc_in),
        .monitor_from_xcvr(mon));
    // ==========================================
    // Expectations and reporting
    function automatic logic [7:0] exp_tx(input logic [32:0] h);
        return h[14] ? 8'h00 : h[7:0];
    endfunction
    function automatic loop_type exp_loop(input logic [32:0] h);
        return h[15] ? 3'h0 : h[10:8];
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Clock, input history as sampled by the device, hang guard
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int k = 3; k > 0; k--) hist[k] <= hist[k-1];
        hist[0] <= {mon, src, inh, eqr, hfo, rrc_in, loop, txd};
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    // Side-band paths checked every cycle once the history is full, except for the four steps after the clock source switch
    always @(negedge clk) if (chk_on) begin
        check("tx_data_out", txq, exp_tx(hist[0]));
        check("loopback", loop_x, exp_loop(hist[2]));
        check("monitor", mon_out, hist[2][32:16]);
        check("reset_done", rrc, hist[2][11]);
        check("lowpower", {eq_x, hf_x}, hist[2][13:12]);
        check("options_off", {rdy_off, loop_off, eq_off, hf_off}, 0);
        check("tx_options_off", tx_off, hist[0][7:0]);
        check("highend", {eq_hi, hf_hi}, 0);
    end
    // ==========================================
    // Stimulus
    task automatic step();
        @(negedge clk);
        {inh, eqr, hfo, loop, txd} = 14'($random(seed));
    endtask
    // One access; dup keeps the request up while it is outstanding
    task automatic access(input logic w, input addr_type a, input data_type d, input bit dup);
        step();
        en = 1;
        we = w;
        addr = a;
        wdata = d;
        step();
        en = dup;
        check("ready_early", rdy, 1'b0);
        step();
        en = 0;
        check("ready", rdy, 1'b1);
        if (!w) check("rdata", rdata, mem[a]);
        if (w) mem[a] = d;
        step();
        check("ready_pulse", rdy, 1'b0);
        if (dup) check("ready_once", rdy, 1'b0);
    endtask
    initial begin
        seed = 32'h0F34;
        {err_count, checks_done, cycles, chk_on, en, we, src} = 0;
        {rst, addr, wdata, inh, eqr, hfo, loop, txd} = {1'b1, 39'h0};
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (4) step();
        chk_on = 1;
        // No access before receive reset completes
        while (rrc !== 1'b1) step();
        for (i = 0; i < 8; i++) begin
            wa[i] = (i == 0) ? 9'h000 : (i == 7) ? 9'h1FF : 9'($random(seed));
            access(1'b1, wa[i], 16'($random(seed)), i == 5);
        end
        for (i = 0; i < 8; i++) access(1'b0, wa[i], 16'h0000, i == 3);
        $display("test reconfiguration done");
        // Recovered receive clock: loopback must fall back to default
        chk_on = 0;
        src = 1;
        repeat (4) step();
        chk_on = 1;
        repeat (40) step();
        $display("test loopback override done");
        results();
    end
endmodule
